// File: inc/mcu_exec_map.svh
`ifndef MCU_EXEC_MAP_SVH
`define MCU_EXEC_MAP_SVH
// apb byte offsets
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_PC        8'h08
`define OFS_WREG      8'h0c
`define OFS_STACK     8'h10
`define OFS_WDOG      8'h14
`define OFS_FADDR     8'h18
`define OFS_FDATA     8'h1c
// field positions
`define CTRL_RUN_BIT  0
`define STAT_Z_BIT    0
`define STAT_TO_BIT   1
`define STAT_PD_BIT   2
`define STAT_NOP_BIT  3
`define DEST_BIT      7
// reset values
`define RST_PC        12'h000
`define RST_W         8'h00
`define RST_FLAG_TO   1'b1
`define RST_FLAG_PD   1'b1
// watchdog count at which timeout is flagged
`define WDOG_LIMIT    8'hff
// opcode patterns for casez
`define OP_BTFS_SET   14'b01_011?_????_????
`define OP_CALL_SUB   14'b10_????_????_????
`define OP_CLR_FILE   14'b00_0001_1???_????
`define OP_CLR_WORK   14'h0140
`define OP_CLR_WDOG   14'h0004
`define OP_COMP_FILE  14'b00_1001_????_????
`define OP_DEC_FILE   14'b00_0011_????_????
`endif

// File: inc/mcu_exec_pkg.sv
package mcu_exec_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        S_HALT,
        S_EXEC,
        S_NOP
    } seq_e;
    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    // state of the core apart from the data register file
    typedef struct packed {
        seq_e        st;
        logic        run;
        logic [11:0] pc;
        logic [7:0]  w;
        logic [11:0] top_of_return_stack;
        logic        z;
        logic        tof;
        logic        pdf;
        logic [7:0]  wdt;
        logic [6:0]  faddr;
        logic [31:0] prdata;
        logic        pslverr;
    } core_s;
endpackage

// File: verilog/mcu_instruction_subset_exec.sv
`timescale 1ns/1ps
`include "mcu_exec_map.svh"
module mcu_instruction_subset_exec (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire mcu_exec_pkg::apb_req_s apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // program memory fetch (asynchronous read)
    output logic [11:0]                prog_addr,
    input  wire logic [13:0]           prog_word
);
    import mcu_exec_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // storage
    core_s      s_q;          // registered state
    core_s      s_d;          // next state
    logic [7:0] file_mem [128]; // data register file

    // decoded fields of the fetched word
    logic [6:0] fa;           // byte-op file address
    logic [5:0] ba;           // bit-op file address
    logic [2:0] bsel;         // bit index
    logic       dst;          // destination select
    logic [7:0] fval;         // file operand
    logic [7:0] bval;         // bit-op operand
    logic       exec;         // an instruction executes this cycle
    // file write port shared by core and apb
    logic       fwe;
    logic [6:0] fwa;
    logic [7:0] fwd;
    logic       core_fwe;     // core writes this cycle
    logic [7:0] res;          // alu result
    // apb decode
    logic       setup;
    logic       wr_acc;

    assign fa   = prog_word[6:0];
    assign dst  = prog_word[`DEST_BIT];
    assign ba   = prog_word[5:0];
    assign bsel = prog_word[8:6];
    assign fval = file_mem[fa];
    assign bval = file_mem[{1'b0, ba}];
    assign exec = (s_q.st == S_EXEC) && s_q.run;
    assign prog_addr = s_q.pc;
    assign setup  = apb_req.psel && !apb_req.penable;
    assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;

    ////////////////////////////////////////////////////////////////////
    // next-state logic: sequencer, alu, watchdog, apb registers
    always_comb begin
        s_d      = s_q;
        core_fwe = 1'b0;
        res      = 8'h00;
        // watchdog runs while the core runs; timeout drops to-flag
        if (s_q.run && s_q.wdt != `WDOG_LIMIT) begin
            s_d.wdt = s_q.wdt + 8'h01;
        end else if (s_q.run) begin
            s_d.tof = 1'b0;
        end
        case (s_q.st)
            // stopped: wait for run
            S_HALT: begin
                if (s_q.run) begin
                    s_d.st = S_EXEC;
                end
            end
            // execute the word at pc
            S_EXEC: begin
                if (!s_q.run) begin
                    s_d.st = S_HALT;
                end else begin
                    s_d.pc = s_q.pc + 12'h001;
                    casez (prog_word)
                        // skip the next word when the bit is set
                        `OP_BTFS_SET: begin
                            if (bval[bsel]) begin
                                s_d.pc = s_q.pc + 12'h002;
                                s_d.st = S_NOP;
                            end
                        end
                        // push return address, jump, then idle once
                        `OP_CALL_SUB: begin
                            s_d.top_of_return_stack = s_q.pc + 12'h001;
                            s_d.pc  = prog_word[11:0];
                            s_d.st  = S_NOP;
                        end
                        // clear file register
                        `OP_CLR_FILE: begin
                            core_fwe = 1'b1;
                            res      = 8'h00;
                            s_d.z    = 1'b1;
                        end
                        // clear working register
                        `OP_CLR_WORK: begin
                            s_d.w = 8'h00;
                            s_d.z = 1'b1;
                        end
                        // clear watchdog and restore flags
                        `OP_CLR_WDOG: begin
                            s_d.wdt = 8'h00;
                            s_d.tof = 1'b1;
                            s_d.pdf = 1'b1;
                        end
                        // complement into w or file
                        `OP_COMP_FILE: begin
                            res      = ~fval;
                            s_d.z    = (res == 8'h00);
                            core_fwe = dst;
                            if (!dst) begin
                                s_d.w = res;
                            end
                        end
                        // decrement into w or file
                        `OP_DEC_FILE: begin
                            res      = fval - 8'h01;
                            s_d.z    = (res == 8'h00);
                            core_fwe = dst;
                            if (!dst) begin
                                s_d.w = res;
                            end
                        end
                        // words outside the subset pass as no-ops
                        default: begin
                            s_d.pc = s_q.pc + 12'h001;
                        end
                    endcase
                end
            end
            // discarded slot after skip or call
            S_NOP: begin
                s_d.st = s_q.run ? S_EXEC : S_HALT;
            end
            default: begin
                s_d.st = S_HALT;
            end
        endcase
        // apb writes take effect in the access phase
        if (wr_acc) begin
            case (apb_req.paddr)
                `OFS_CTRL: begin
                    s_d.run = apb_req.pwdata[`CTRL_RUN_BIT];
                end
                `OFS_FADDR: begin
                    s_d.faddr = apb_req.pwdata[6:0];
                end
                default: begin
                    s_d.run = s_d.run;
                end
            endcase
        end
        // read data and error latched in setup, shown in access
        if (setup) begin
            s_d.pslverr = 1'b0;
            case (apb_req.paddr)
                `OFS_CTRL: begin
                    s_d.prdata = {31'h0, s_q.run};
                end
                `OFS_STATUS: begin
                    s_d.prdata = {28'h0, s_q.st == S_NOP, s_q.pdf,
                                  s_q.tof, s_q.z};
                end
                `OFS_PC: begin
                    s_d.prdata = {20'h0, s_q.pc};
                end
                `OFS_WREG: begin
                    s_d.prdata = {24'h0, s_q.w};
                end
                `OFS_STACK: begin
                    s_d.prdata = {20'h0, s_q.top_of_return_stack};
                end
                `OFS_WDOG: begin
                    s_d.prdata = {24'h0, s_q.wdt};
                end
                `OFS_FADDR: begin
                    s_d.prdata = {25'h0, s_q.faddr};
                end
                `OFS_FDATA: begin
                    s_d.prdata = {24'h0, file_mem[s_q.faddr]};
                end
                // unmapped: zero data and an error
                default: begin
                    s_d.prdata  = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // file write arbitration: the core wins over an apb write
    always_comb begin
        fwe = core_fwe;
        fwa = fa;
        fwd = res;
        if (!core_fwe && wr_acc && apb_req.paddr == `OFS_FDATA) begin
            fwe = 1'b1;
            fwa = s_q.faddr;
            fwd = apb_req.pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q         <= '0;
            s_q.st      <= S_HALT;
            s_q.pc      <= `RST_PC;
            s_q.w       <= `RST_W;
            s_q.tof     <= `RST_FLAG_TO;
            s_q.pdf     <= `RST_FLAG_PD;
        end else begin
            s_q <= s_d;
        end
    end

    // data register file, no reset
    always_ff @(posedge pclk) begin
        if (fwe) begin
            file_mem[fwa] <= fwd;
        end
    end

    // bus outputs
    assign prdata  = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign pready  = 1'b1;

    ////////////////////////////////////////////////////////////////////
    // assertions
    logic is_btfs;
    logic is_call;
    logic is_clear_file_register;
    logic is_complement_file_register;
    logic is_decrement_file_register;
    assign is_btfs = exec && prog_word ==? `OP_BTFS_SET;
    assign is_call = exec && prog_word ==? `OP_CALL_SUB;
    assign is_clear_file_register = exec && prog_word ==? `OP_CLR_FILE;
    assign is_complement_file_register = exec && prog_word ==? `OP_COMP_FILE;
    assign is_decrement_file_register = exec && prog_word ==? `OP_DEC_FILE;

    sequence q_call_slot;
        s_q.st == S_NOP ##1 s_q.st != S_NOP;
    endsequence

    property p_skip_set;
        @(posedge pclk) disable iff (!presetn)
        is_btfs && bval[bsel] |=>
            s_q.st == S_NOP && s_q.pc == $past(s_q.pc) + 12'h002;
    endproperty
    a_skip_set: assert property (p_skip_set)
        else $error("bit set did not skip");

    property p_skip_clear;
        @(posedge pclk) disable iff (!presetn)
        is_btfs && !bval[bsel] |=>
            s_q.st != S_NOP && s_q.pc == $past(s_q.pc) + 12'h001;
    endproperty
    a_skip_clear: assert property (p_skip_clear)
        else $error("bit clear did not fall through");

    property p_call_target;
        @(posedge pclk) disable iff (!presetn)
        is_call |=> s_q.pc == $past(prog_word[11:0])
            && s_q.top_of_return_stack == $past(s_q.pc) + 12'h001;
    endproperty
    a_call_target: assert property (p_call_target)
        else $error("call target or return address wrong");

    property p_call_two;
        @(posedge pclk) disable iff (!presetn)
        is_call |=> q_call_slot;
    endproperty
    a_call_two: assert property (p_call_two)
        else $error("call not two cycles");

    property p_call_hold;
        @(posedge pclk) disable iff (!presetn)
        is_call |=> s_q.pc == $past(prog_word[11:0]) ##1 $stable(s_q.pc);
    endproperty
    a_call_hold: assert property (p_call_hold)
        else $error("pc moved in call slot");

    property p_clear_file_register;
        @(posedge pclk) disable iff (!presetn)
        is_clear_file_register |-> fwe && fwd == 8'h00 && fwa == fa ##1 s_q.z;
    endproperty
    a_clear_file_register: assert property (p_clear_file_register)
        else $error("clear file failed");

    property p_clear_working_register;
        @(posedge pclk) disable iff (!presetn)
        exec && prog_word == `OP_CLR_WORK |=> s_q.w == 8'h00 && s_q.z;
    endproperty
    a_clear_working_register: assert property (p_clear_working_register)
        else $error("clear w failed");

    property p_clear_watchdog_timer;
        @(posedge pclk) disable iff (!presetn)
        exec && prog_word == `OP_CLR_WDOG |=>
            s_q.wdt == 8'h00 && s_q.tof && s_q.pdf;
    endproperty
    a_clear_watchdog_timer: assert property (p_clear_watchdog_timer)
        else $error("clear watchdog failed");

    property p_complement_file_register_w;
        @(posedge pclk) disable iff (!presetn)
        is_complement_file_register && !dst |=> s_q.w == ~$past(fval)
            && s_q.z == ($past(fval) == 8'hff);
    endproperty
    a_complement_file_register_w: assert property (p_complement_file_register_w)
        else $error("complement to w wrong");

    property p_decrement_file_register_f;
        @(posedge pclk) disable iff (!presetn)
        is_decrement_file_register && dst |-> fwe && fwd == fval - 8'h01 ##1
            s_q.z == ($past(fval) == 8'h01);
    endproperty
    a_decrement_file_register_f: assert property (p_decrement_file_register_f)
        else $error("decrement to file wrong");

    property p_dest_keep_w;
        @(posedge pclk) disable iff (!presetn)
        (is_complement_file_register || is_decrement_file_register) && dst |=> $stable(s_q.w);
    endproperty
    a_dest_keep_w: assert property (p_dest_keep_w)
        else $error("w changed with destination file");
endmodule

// File: testbench/prog_mem_model.sv
`timescale 1ns/1ps
// program memory beside the core: read without a clock, no wait
module prog_mem_model (
    // fetch port
    input  wire logic [11:0] addr,
    output logic      [13:0] word
);
    logic [13:0] mem [4096]; // words, filled by the bench
    // empty slots hold a word outside the subset
    initial begin
        foreach (mem[i]) mem[i] = 14'h0000;
    end
    // word at the address in the same cycle
    assign word = mem[addr];
endmodule

// File: testbench/tb_mcu_instruction_subset_exec.sv
`timescale 1ns/1ps
`include "mcu_exec_map.svh"
module tb_mcu_instruction_subset_exec;
    import mcu_exec_pkg::*;
    logic        pclk;         // bus clock
    logic        presetn;      // reset, active low
    apb_req_s    req;          // apb request
    logic [31:0] prdata;       // read data
    logic        pready;       // access done
    logic        pslverr;      // access error
    logic [11:0] prog_addr;    // fetch address
    logic [13:0] prog_word;    // fetched word
    int          miscompares;  // mismatches
    int          total_checks; // comparisons
    logic [65:0] rdq [$];      // {mask, error, data} per read
    logic [15:0] pcq [$];      // {address, dwell} per pc move
    logic [31:0] rnd;          // xorshift state
    logic [7:0]  fm [128];     // expected file registers
    logic [7:0]  ew;           // expected working register
    logic        ez;           // expected zero flag
    logic [11:0] p;            // slot of the next step
    logic        trc;          // pc trace on
    logic        seen1;        // first move passed
    logic [11:0] last_pc;      // pc before the move
    int          dwell;        // cycles the pc stood
    ////////////////////////////////////////////////////////////
    // clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    mcu_instruction_subset_exec dut (.pclk(pclk), .presetn(presetn),
        .apb_req(req), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_word(prog_word));
    prog_mem_model pm (.addr(prog_addr), .word(prog_word));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // compare and count
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one apb transfer, held until pready at a rising edge
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    // read with a note of what must come back
    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [32:0] m);
        rdq.push_back({m, e});
        xfer(a, 1'b0, 32'h0);
    endtask
    task automatic setf(input logic [6:0] a, input logic [7:0] v);
        xfer(`OFS_FADDR, 1'b1, 32'(a));
        xfer(`OFS_FDATA, 1'b1, 32'(v));
        fm[a] = v;
    endtask
    task automatic chkf(input logic [6:0] a);
        xfer(`OFS_FADDR, 1'b1, 32'(a));
        rd(`OFS_FDATA, 33'(fm[a]), '1);
    endtask
    task automatic run_for(input int n);
        xfer(`OFS_CTRL, 1'b1, 32'h1);
        repeat (n) @(posedge pclk);
        xfer(`OFS_CTRL, 1'b1, 32'h0);
    endtask
    // one instruction, then a call to itself parks the core
    task automatic step(input logic [13:0] op);
        pm.mem[p] = op;
        pm.mem[p + 12'h1] = 14'h2000 | 14'(p + 12'h1);
        run_for(8);
        p = p + 12'h1;
    endtask
    ////////////////////////////////////////////////////////////
    // read results against the oldest note
    always @(posedge pclk) begin
        logic [65:0] n;
        if (req.psel && req.penable && pready === 1'b1 && !req.pwrite
            && rdq.size() > 0) begin
            n = rdq.pop_front();
            check({pslverr, prdata} & n[65:33], n[32:0] & n[65:33]);
        end
    end
    // how long each pc value stood
    always @(posedge pclk) begin
        if (trc && prog_addr !== last_pc) begin
            if (seen1 && pcq.size() > 0)
                check(33'({last_pc, dwell[3:0]}), 33'(pcq.pop_front()));
            seen1 = 1'b1;
            last_pc = prog_addr;
            dwell = 1;
        end else begin
            dwell = dwell + 1;
        end
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        close_out();
    end
    ////////////////////////////////////////////////////////////
    initial begin
        logic [6:0]  a;
        logic [7:0]  v;
        logic [7:0]  r;
        logic        d;
        logic [13:0] op;
        logic [2:0]  b;
        presetn = 1'b0;
        req = '0;
        {trc, seen1, ew, ez, p, last_pc} = '0;
        {miscompares, total_checks, dwell} = '0;
        rnd = 32'h2d97;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and an unmapped place
        rd(`OFS_STATUS, 33'h6, 33'h7);
        rd(`OFS_WREG, 33'h0, '1);
        rd(`OFS_WDOG, 33'h0, '1);
        rd(8'h20, {1'b1, 32'h0}, '1);
        // loop at 0 until the watchdog count runs out
        pm.mem[0] = 14'h2000;
        run_for(300);
        rd(`OFS_STATUS, 33'h4, 33'h7);
        rd(`OFS_STACK, 33'h1, '1);
        // random data ops, zero result in three of every five
        for (int i = 0; i < 10; i++) begin
            rnd = xs(rnd);
            a = rnd[6:0];
            d = rnd[16];
            v = (i % 5 == 4) ? 8'h01 : rnd[15:8];
            setf(a, v);
            r = 8'h00;
            case (i % 5)
                0: begin
                    op = {6'b001001, d, a};
                    r = ~v;
                end
                2: op = {7'b0000011, a};
                3: op = 14'h0140;
                default: begin
                    op = {6'b000011, d, a};
                    r = v - 8'h01;
                end
            endcase
            if (i % 5 == 3) ew = 8'h00;
            else if (i % 5 == 2 || d) fm[a] = r;
            else ew = r;
            ez = (r == 8'h00);
            step(op);
            rd(`OFS_WREG, 33'(ew), '1);
            rd(`OFS_STATUS, 33'(ez), 33'h1);
            chkf(a);
            rd(`OFS_PC, 33'(p), '1);
        end
        // watchdog clear after timeout
        step(14'h0004);
        rd(`OFS_STATUS, 33'h6, 33'h6);
        rd(`OFS_WDOG, 33'h0, 33'hf0);
        // call, skip taken, skip not taken, clear w
        rnd = xs(rnd);
        a = {1'b0, rnd[5:0]};
        b = rnd[10:8];
        setf(a, 8'h01 << b);
        pm.mem[p] = 14'h2000 | 14'(p + 12'h8);
        pm.mem[p + 12'h8] = {5'b01011, b, a[5:0]};
        pm.mem[p + 12'h9] = {7'b0000011, a};
        pm.mem[p + 12'ha] = {5'b01011, b + 3'h1, a[5:0]};
        pm.mem[p + 12'hb] = 14'h0140;
        pm.mem[p + 12'hc] = 14'h2000 | 14'(p + 12'hc);
        pcq.push_back({p + 12'h8, 4'h2});
        pcq.push_back({p + 12'ha, 4'h2});
        pcq.push_back({p + 12'hb, 4'h1});
        last_pc = prog_addr;
        trc = 1'b1;
        run_for(12);
        trc = 1'b0;
        check(33'(pcq.size()), 33'h0);
        rd(`OFS_PC, 33'(p + 12'hc), '1);
        rd(`OFS_STACK, 33'(p + 12'hd), '1);
        chkf(a);
        rd(`OFS_WREG, 33'h0, '1);
        // run bit reads back cleared; every noted read was compared
        rd(`OFS_CTRL, 33'h0, '1);
        @(posedge pclk);
        check(33'(rdq.size()), 33'h0);
        close_out();
    end
endmodule
